// *** verilog/pmdc_core.sv ***
// Closed-loop duty controller: periodic PID step, wind-up guards,
// dead zone with hysteresis, saturation, and PWM drive of an H-bridge.
// Assumes feedback and target written by software over the plain port.
//
// Functional notes
// - Duty is P*err plus I*integ plus D*deriv
// - Integral adds error once each period
// - Derivative is error minus previous error
// - Error is scaled feedback minus target
// - Gains are numerator over power of two
// - Integral shift limited to 3..18
// - One calculation per configurable period
// - Integral magnitude clamped to limit
// - Optional integral reset on large proportional
// - Inside dead zone: zero duty, clear integral
// - Leave dead zone above twice its width
// - Applied duty spans -600 to 600
// - Positive duty drives A high, B low
// - Inversion swaps the two outputs
// - Carrier selectable at 20 or 5 kHz
// - Feedback off: duty is target minus 2048
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module pmdc_core
  import pmdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // Bridge drive
  output logic out_a_q,
  output logic out_b_q,
  // Period strobe for observation
  output logic step_q
);

  typedef enum logic [1:0] {
    PMDC_IDLE = 2'b00,
    PMDC_CALC = 2'b01,
    PMDC_APPLY = 2'b10
  } pmdc_state_e;

  // ********************************************************
  // Helpers
  // ********************************************************
  // Scales by numerator then arithmetic shift; 64 bits avoid wrap.
  function automatic logic signed [63:0] gain(
    input logic signed [31:0] v, input logic [20:0] c);
    logic signed [63:0] p;
    p = 64'(v) * $signed({48'h0, c[15:0]});
    gain = p >>> c[COEF_SH_LSB +: 5];
  endfunction

  function automatic logic signed [31:0] absv(input logic signed [31:0] v);
    absv = v[31] ? -v : v;
  endfunction

  // ********************************************************
  // Software registers
  // ********************************************************
  logic [4:0] ctrl_q;
  logic [11:0] target_q;
  logic [11:0] fbk_q;
  logic [20:0] pcoef_q;
  logic [20:0] icoef_q;
  logic [20:0] dcoef_q;
  logic [31:0] period_q;
  logic [14:0] ilimit_q;
  logic [11:0] dzone_q;
  logic [9:0] maxduty_q;
  logic [4:0] ish_w;

  // Out-of-range integral shift is pulled into 3..18 on write
  always_comb begin
    ish_w = reg_wdata[COEF_SH_LSB +: 5];
    if (ish_w < ISHIFT_MIN) ish_w = ISHIFT_MIN;
    if (ish_w > ISHIFT_MAX) ish_w = ISHIFT_MAX;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      target_q <= TARGET_RST;
      fbk_q <= TARGET_RST;
      pcoef_q <= '0;
      icoef_q <= {ISHIFT_MIN, 16'h0};
      dcoef_q <= '0;
      period_q <= PERIOD_RST;
      ilimit_q <= ILIMIT_RST;
      dzone_q <= '0;
      maxduty_q <= MAXDUTY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: ctrl_q <= reg_wdata[4:0];
        ADDR_TARGET: target_q <= reg_wdata[11:0];
        ADDR_FEEDBACK: fbk_q <= reg_wdata[11:0];
        ADDR_PCOEF: pcoef_q <= reg_wdata[20:0];
        ADDR_ICOEF: icoef_q <= {ish_w, reg_wdata[15:0]};
        ADDR_DCOEF: dcoef_q <= reg_wdata[20:0];
        ADDR_PERIOD: period_q <= (reg_wdata == 32'h0) ? 32'h1 : reg_wdata;
        ADDR_ILIMIT: ilimit_q <= reg_wdata[14:0];
        ADDR_DEADZONE: dzone_q <= reg_wdata[11:0];
        ADDR_MAXDUTY: begin
          maxduty_q <= (reg_wdata[9:0] > 10'(DUTY_MAX)) ? 10'(DUTY_MAX)
                                                      : reg_wdata[9:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ********************************************************
  // Period timer
  // ********************************************************
  logic [31:0] tick_q;
  logic tick;
  assign tick = ctrl_q[CTRL_RUN] && (tick_q >= period_q - 32'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
    end else if (tick || !ctrl_q[CTRL_RUN]) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // ********************************************************
  // Control step
  // ********************************************************
  pmdc_state_e state_q;
  logic signed [31:0] err_q;
  logic signed [31:0] perr_q;
  logic signed [31:0] integ_q;
  logic signed [15:0] duty_q;
  logic dz_q;
  logic signed [31:0] err_w;
  logic signed [31:0] isum;
  logic signed [31:0] ilim;
  logic signed [31:0] iclmp;
  logic signed [63:0] pterm;
  logic signed [63:0] sum;
  logic signed [31:0] mag_e;
  logic dz_next;
  logic signed [15:0] sat;

  always_comb begin
    err_w = 32'($signed({1'b0, fbk_q}))
      - 32'($signed({1'b0, target_q}));
    mag_e = absv(err_q);
    dz_next = dz_q
      ? (mag_e <= 32'($signed({1'b0, dzone_q, 1'b0})))
      : (mag_e < 32'($signed({1'b0, dzone_q})));
    ilim = 32'($signed({1'b0, ilimit_q}));
    isum = integ_q + err_q;
    iclmp = isum > ilim ? ilim : (isum < -ilim ? -ilim : isum);
    pterm = gain(err_q, pcoef_q);
    if (ctrl_q[CTRL_IRESET] &&
        absv(32'(pterm)) > 32'($signed({1'b0, maxduty_q}))) begin
      iclmp = '0;
    end
    if (dz_next) iclmp = '0;
    sum = pterm + gain(iclmp, icoef_q)
      + gain(err_q - perr_q, dcoef_q);
    if (!ctrl_q[CTRL_FB_EN]) begin
      sum = 64'($signed({1'b0, target_q})) - 64'(TARGET_MID);
    end else if (dz_next) begin
      sum = '0;
    end
    if (sum > 64'(DUTY_MAX)) sat = DUTY_MAX;
    else if (sum < -64'(DUTY_MAX)) sat = -DUTY_MAX;
    else sat = 16'(sum);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PMDC_IDLE;
      err_q <= '0;
      perr_q <= '0;
      integ_q <= '0;
      duty_q <= '0;
      dz_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      step_q <= 1'b0;
      case (state_q)
        PMDC_IDLE: begin
          if (tick) begin
            err_q <= err_w;
            state_q <= PMDC_CALC;
          end
        end
        PMDC_CALC: begin
          integ_q <= ctrl_q[CTRL_FB_EN] ? iclmp : '0;
          dz_q <= ctrl_q[CTRL_FB_EN] & dz_next;
          duty_q <= sat;
          state_q <= PMDC_APPLY;
        end
        PMDC_APPLY: begin
          perr_q <= err_q;
          step_q <= 1'b1;
          state_q <= PMDC_IDLE;
        end
        default: state_q <= PMDC_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Read port
  // ********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata_q <= {27'h0, ctrl_q};
        ADDR_TARGET: reg_rdata_q <= {20'h0, target_q};
        ADDR_FEEDBACK: reg_rdata_q <= {20'h0, fbk_q};
        ADDR_PCOEF: reg_rdata_q <= {11'h0, pcoef_q};
        ADDR_ICOEF: reg_rdata_q <= {11'h0, icoef_q};
        ADDR_DCOEF: reg_rdata_q <= {11'h0, dcoef_q};
        ADDR_PERIOD: reg_rdata_q <= period_q;
        ADDR_ILIMIT: reg_rdata_q <= {17'h0, ilimit_q};
        ADDR_DEADZONE: reg_rdata_q <= {20'h0, dzone_q};
        ADDR_MAXDUTY: reg_rdata_q <= {22'h0, maxduty_q};
        ADDR_DUTY: reg_rdata_q <= 32'(duty_q);
        ADDR_INTEG: reg_rdata_q <= integ_q;
        ADDR_STATUS: reg_rdata_q <= {30'h0, state_q != PMDC_IDLE, dz_q};
        default: reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // ********************************************************
  // PWM stage
  // ********************************************************
  pmdc_pwm_if pwm_bus ();
  assign pwm_bus.duty = duty_q;
  assign pwm_bus.invert = ctrl_q[CTRL_INVERT];
  assign pwm_bus.slow = ctrl_q[CTRL_SLOW];

  pmdc_pwm pmdc_pwm_inst (
    .clk(clk),
    .rst(rst),
    .cfg(pwm_bus.pwm),
    .out_a_q(out_a_q),
    .out_b_q(out_b_q)
  );

  // ********************************************************
  // Checks
  // ********************************************************
  sequence calc_seq;
    state_q == PMDC_IDLE && tick ##1 state_q == PMDC_CALC;
  endsequence

  duty_range_a: assert property (@(posedge clk) disable iff (rst)
    duty_q <= DUTY_MAX && duty_q >= -DUTY_MAX)
    else $error("duty outside range");
  // Checked as a step lands; a lowered limit only bites at the next step
  integ_clamp_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == PMDC_APPLY && $stable(ilimit_q)) |->
    absv(integ_q) <= 32'($signed({1'b0, ilimit_q})))
    else $error("integral above limit");
  step_once_a: assert property (@(posedge clk) disable iff (rst)
    calc_seq |-> ##2 step_q)
    else $error("step did not complete");
  run_stop_a: assert property (@(posedge clk) disable iff (rst)
    (!ctrl_q[CTRL_RUN] && state_q == PMDC_IDLE) |=> state_q == PMDC_IDLE)
    else $error("step started while stopped");
  // Open loop: a target 600 or more above mid scale is full forward
  open_loop_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == PMDC_CALC && !ctrl_q[CTRL_FB_EN] && target_q >= 12'ha58)
    |=> duty_q == DUTY_MAX)
    else $error("open loop duty wrong");
  dead_zone_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == PMDC_CALC && ctrl_q[CTRL_FB_EN] && dz_next)
    |=> duty_q == 16'sh0 && integ_q == 32'sh0)
    else $error("dead zone not zeroed");
  // Wind-up guard: a large proportional term empties the integral
  ireset_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == PMDC_CALC && ctrl_q[CTRL_FB_EN] && ctrl_q[CTRL_IRESET] &&
     absv(32'(pterm)) > 32'($signed({1'b0, maxduty_q})))
    |=> integ_q == 32'sh0)
    else $error("integral not reset on large proportional term");
  err_sign_a: assert property (@(posedge clk) disable iff (rst)
    calc_seq |-> err_q == $past(err_w))
    else $error("error sample wrong");
  deriv_keep_a: assert property (@(posedge clk) disable iff (rst)
    state_q == PMDC_APPLY |=> perr_q == $past(err_q))
    else $error("previous error not stored");

endmodule // pmdc_core

// *** verilog/pmdc_pkg.sv ***
// Constants shared by the duty controller core and its PWM generator.
// Assumes a 100 MHz system clock and 12-bit scaled feedback and target.
package pmdc_pkg;

  // ********************************************************
  // Clock and timing
  // ********************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PWM_FAST_HZ = 20_000;
  localparam int unsigned PWM_SLOW_HZ = 5_000;
  localparam int unsigned PWM_FAST_CYC = CLK_HZ / PWM_FAST_HZ;
  localparam int unsigned PWM_SLOW_CYC = CLK_HZ / PWM_SLOW_HZ;

  // ********************************************************
  // Register map, word addresses on the plain port
  // ********************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TARGET = 4'h1;
  localparam logic [3:0] ADDR_FEEDBACK = 4'h2;
  localparam logic [3:0] ADDR_PCOEF = 4'h3;
  localparam logic [3:0] ADDR_ICOEF = 4'h4;
  localparam logic [3:0] ADDR_DCOEF = 4'h5;
  localparam logic [3:0] ADDR_PERIOD = 4'h6;
  localparam logic [3:0] ADDR_ILIMIT = 4'h7;
  localparam logic [3:0] ADDR_DEADZONE = 4'h8;
  localparam logic [3:0] ADDR_MAXDUTY = 4'h9;
  localparam logic [3:0] ADDR_DUTY = 4'ha;
  localparam logic [3:0] ADDR_INTEG = 4'hb;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // Control register bit positions
  localparam int unsigned CTRL_FB_EN = 0;
  localparam int unsigned CTRL_IRESET = 1;
  localparam int unsigned CTRL_INVERT = 2;
  localparam int unsigned CTRL_SLOW = 3;
  localparam int unsigned CTRL_RUN = 4;

  // Coefficient layout: numerator [15:0], shift exponent [20:16]
  localparam int unsigned COEF_SH_LSB = 16;

  // ********************************************************
  // Ranges and reset values
  // ********************************************************
  localparam logic signed [15:0] DUTY_MAX = 16'sd600;
  localparam logic signed [15:0] TARGET_MID = 16'sd2048;
  localparam logic [14:0] ILIMIT_MAX = 15'h7fff;
  localparam logic [4:0] ISHIFT_MIN = 5'h03;
  localparam logic [4:0] ISHIFT_MAX = 5'h12;
  localparam logic [31:0] PERIOD_RST = 32'h000f4240;
  localparam logic [14:0] ILIMIT_RST = 15'h03e8;
  localparam logic [9:0] MAXDUTY_RST = 10'h258;
  localparam logic [11:0] TARGET_RST = 12'h800;
  localparam logic [4:0] CTRL_RST = 5'h11;

endpackage

// *** verilog/pmdc_pwm_if.sv ***
// Interface carrying the applied duty and carrier setup to the PWM stage.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
interface pmdc_pwm_if;
  logic signed [15:0] duty;
  logic invert;
  logic slow;
  modport core (output duty, output invert, output slow);
  modport pwm (input duty, input invert, input slow);
endinterface // pmdc_pwm_if

// *** verilog/pmdc_pwm.sv ***
// PWM generator for the two H-bridge half outputs.
// Assumes duty already saturated to -600..600 by the core.
`timescale 1ns/1ns
module pmdc_pwm
  import pmdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Setup from the core
  pmdc_pwm_if.pwm cfg,
  // Bridge drive
  output logic out_a_q,
  output logic out_b_q
);

  logic [14:0] cnt_q;
  logic [14:0] top;
  logic [14:0] cmp;
  logic [9:0] mag;
  logic drive;
  logic fwd;

  // ********************************************************
  // Carrier and compare
  // ********************************************************
  always_comb begin
    top = cfg.slow ? 15'(PWM_SLOW_CYC - 1)
                   : 15'(PWM_FAST_CYC - 1);
    mag = cfg.duty[15] ? 10'(-cfg.duty) : 10'(cfg.duty);
    // Compare is |duty|/600 of the carrier, so full duty never drops
    cmp = cfg.slow ? 15'((25'(mag) * 25'd20000) / 25'd600)
                   : 15'((25'(mag) * 25'd5000) / 25'd600);
    drive = cnt_q < cmp;
    fwd = ~cfg.duty[15] ^ cfg.invert;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (cnt_q >= top) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 15'd1;
    end
  end

  // Off phase brakes: both outputs low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= drive & fwd;
      out_b_q <= drive & ~fwd;
    end
  end

  full_fwd_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.duty == DUTY_MAX && !cfg.invert) ##1 1 |-> out_a_q && !out_b_q)
    else $error("full forward must drive a only");
  inv_swap_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.duty == DUTY_MAX && cfg.invert) ##1 1 |-> out_b_q && !out_a_q)
    else $error("inverted forward must drive b only");
  no_overlap_a: assert property (@(posedge clk) disable iff (rst)
    !(out_a_q && out_b_q))
    else $error("both bridge outputs high");

endmodule // pmdc_pwm

// *** dv/pmdc_bridge_model.sv ***
// H-bridge stage model: counts drive time on each half output.
// Assumes the bench opens its window over whole carrier periods.
`timescale 1ns/1ns
module pmdc_bridge_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bridge drive from the core
  input wire logic out_a,
  input wire logic out_b,
  // Measurement window and results
  input wire logic win,
  output logic [15:0] cnt_a_q,
  output logic [15:0] cnt_b_q,
  output logic shoot_q
);
  // Both halves high shorts the supply; kept until reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shoot_q <= 1'b0;
    end else if (out_a && out_b) begin
      shoot_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_a_q <= 16'h0;
      cnt_b_q <= 16'h0;
    end else if (!win) begin
      cnt_a_q <= 16'h0;
      cnt_b_q <= 16'h0;
    end else begin
      cnt_a_q <= cnt_a_q + {15'h0, out_a};
      cnt_b_q <= cnt_b_q + {15'h0, out_b};
    end
  end
endmodule // pmdc_bridge_model

// *** dv/tb_pmdc_core.sv ***
// Self-checking bench for the duty controller core.
// Assumes the register map and step timing of the core's package.
`timescale 1ns/1ns
module tb_pmdc_core;
  import pmdc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic win = 1'b0;
  logic [31:0] reg_rdata_q;
  logic out_a_q;
  logic out_b_q;
  logic step_q;
  logic shoot_q;
  logic [15:0] cnt_a_q;
  logic [15:0] cnt_b_q;
  int n_fail = 0;
  int checks = 0;

  always #5 clk = ~clk;

  pmdc_core pmdc_core_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .out_a_q(out_a_q), .out_b_q(out_b_q),
    .step_q(step_q));

  pmdc_bridge_model pmdc_bridge_model_inst (.clk(clk), .rst(rst),
    .out_a(out_a_q), .out_b(out_b_q), .win(win), .cnt_a_q(cnt_a_q),
    .cnt_b_q(cnt_b_q), .shoot_q(shoot_q));

  // ********************************************************
  // Access and compare tasks
  // ********************************************************
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp);
  endtask

  task automatic wait_step(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (step_q !== 1'b1 && k < 100);
      if (step_q !== 1'b1) begin
        check({31'h0, step_q}, 32'h1);
        finish_test();
      end
    end
  endtask

  // Short period keeps the run small; run bit off while configuring
  task automatic setup(input bit cfg);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({30'h0, out_a_q, out_b_q}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    if (cfg) begin
      wr(ADDR_CTRL, 32'h01);
      wr(ADDR_PERIOD, 32'h14);
    end
  endtask

  task automatic pwm_case(input logic [31:0] c, t, d, input bit slow,
                          input logic [15:0] ea, eb);
    int per;
    per = slow ? PWM_SLOW_CYC : PWM_FAST_CYC;
    wr(ADDR_TARGET, t);
    wr(ADDR_CTRL, c);
    wait_step(2);
    rd(ADDR_DUTY, d);
    repeat (per) @(posedge clk);
    win <= 1'b1;
    repeat (per) @(posedge clk);
    win <= 1'b0;
    #1;
    check({16'h0, cnt_a_q}, {16'h0, ea});
    check({16'h0, cnt_b_q}, {16'h0, eb});
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  initial begin
    setup(1'b0);
    rd(ADDR_CTRL, 32'h11);
    rd(ADDR_FEEDBACK, 32'h800);
    rd(ADDR_ICOEF, 32'h0003_0000);
    rd(ADDR_PERIOD, 32'h000f_4240);
    rd(ADDR_ILIMIT, 32'h3e8);
    rd(4'hd, 32'h0);
    wr(4'hd, 32'h5);
    rd(4'hd, 32'h0);
    wr(ADDR_MAXDUTY, 32'h2bc);
    rd(ADDR_MAXDUTY, 32'h258);
    wr(ADDR_ICOEF, 32'h0002_0001);
    rd(ADDR_ICOEF, 32'h0003_0001);
    wr(ADDR_ICOEF, 32'h0013_0001);
    rd(ADDR_ICOEF, 32'h0012_0001);
    wr(ADDR_ILIMIT, 32'h7fff);
    rd(ADDR_ILIMIT, 32'h7fff);
    // Open loop drive through the bridge, both carriers
    setup(1'b1);
    pwm_case(32'h10, 32'h92c, 32'h12c, 1'b0, 16'h9c4, 16'h0);
    pwm_case(32'h14, 32'hfff, 32'h258, 1'b0, 16'h0, 16'h1388);
    pwm_case(32'h18, 32'h76a, 32'hffff_ff6a, 1'b1, 16'h0, 16'h1388);
    pwm_case(32'h10, 32'hfff, 32'h258, 1'b0, 16'h1388, 16'h0);
    pwm_case(32'h10, 32'h0, 32'hffff_fda8, 1'b0, 16'h0, 16'h1388);
    // Proportional plus derivative; previous error is zero after reset
    setup(1'b1);
    wr(ADDR_PCOEF, 32'h1);
    wr(ADDR_DCOEF, 32'h0001_0002);
    wr(ADDR_FEEDBACK, 32'h850);
    wr(ADDR_CTRL, 32'h11);
    wait_step(1);
    rd(ADDR_DUTY, 32'ha0);
    wait_step(1);
    rd(ADDR_DUTY, 32'h50);
    // Running sum, clamp both ways, then reset on a large P term
    setup(1'b1);
    wr(ADDR_ILIMIT, 32'h14);
    wr(ADDR_FEEDBACK, 32'h808);
    wr(ADDR_CTRL, 32'h11);
    wait_step(1);
    rd(ADDR_INTEG, 32'h8);
    wait_step(1);
    rd(ADDR_INTEG, 32'h10);
    wait_step(1);
    rd(ADDR_INTEG, 32'h14);
    wr(ADDR_FEEDBACK, 32'h7f8);
    wait_step(6);
    rd(ADDR_INTEG, 32'hffff_ffec);
    wr(ADDR_PCOEF, 32'h1);
    wr(ADDR_MAXDUTY, 32'h4);
    wr(ADDR_CTRL, 32'h13);
    wait_step(2);
    rd(ADDR_INTEG, 32'h0);
    // Dead zone of 10 with hysteresis, negative errors
    setup(1'b1);
    wr(ADDR_PCOEF, 32'h1);
    wr(ADDR_DEADZONE, 32'ha);
    wr(ADDR_FEEDBACK, 32'h7fb);
    wr(ADDR_CTRL, 32'h11);
    wait_step(2);
    rd(ADDR_DUTY, 32'h0);
    rd(ADDR_INTEG, 32'h0);
    wr(ADDR_FEEDBACK, 32'h7f1);
    wait_step(2);
    rd(ADDR_DUTY, 32'h0);
    wr(ADDR_FEEDBACK, 32'h7e7);
    wait_step(2);
    rd(ADDR_DUTY, 32'hffff_ffe7);
    check({31'h0, shoot_q}, 32'h0);
    finish_test();
  end
endmodule // tb_pmdc_core
